// File: ssio_regs.vh
// How it works
// - Shift clock is the 3 MHz processor clock divided by four, 750 kHz.
// - One shared shift clock output feeds every serial receiver.
// - Writing a byte to the shifter starts a transfer, MSB first.
// - Bit counter stops divider and clock after eight bits.
// - Strobe generator decodes address bits 0 to 3.
// - Only one strobe is active; the others stay idle.
// - Codes 0..10 map to synth, DAC, PLL3, PLL2, rear1, rear2, display, keys, BFO, presel, wheel.
// - Shifter and strobe generator answer only to their own selects.
// - ADC channel is taken from address bits 0 to 3.
// - ADC yields an 8-bit result read on the data bus.
// - ADC raises end-of-conversion when the result is complete.
// - End-of-conversion is seen on second port B bit 7.
// - First port device: 8-bit input, 8-bit output, 6-bit output.
// - Second port device: two 8-bit inputs, one 8-bit output.
// - Each port device answers only to its own distinct select.
// - Port inputs carry lock and check status; outputs drive audio controls.
`ifndef SSIO_REGS_VH
`define SSIO_REGS_VH
`define SSIO_CLK_HZ 10000000
`define SSIO_SCLK_HZ 750000
`define SSIO_CPU_HZ 3000000
`define SSIO_CPU_DIV 4
`define SSIO_NBITS 4'h8
`define SSIO_NSTROBES 11
`define SSIO_ADC_CYC 8'h40
`define SSIO_PA_ADDR 2'h0
`define SSIO_PB_ADDR 2'h1
`define SSIO_PC_ADDR 2'h2
`define SSIO_RST_BYTE 8'h00
`endif

// File: ssio_top.v
`timescale 1ns/100ps
`default_nettype none
`include "ssio_regs.vh"
module ssio_top (
    input wire clk,
    input wire arst_n,
    input wire cpu_clk_en,
    input wire io_sel,
    input wire wr_n,
    input wire rd_n,
    input wire [3:0] addr,
    input wire [7:0] wdata,
    input wire shifter_select,
    input wire strobe_gen_select,
    input wire adc_select,
    input wire port_a_device_select,
    input wire port_b_device_select,
    input wire [7:0] p1_in,
    input wire [7:0] p2a_in,
    input wire [6:0] p2b_in,
    input wire [7:0] adc_sample,
    output reg [7:0] rdata,
    output reg rdata_valid,
    output reg sclk,
    output reg sdata,
    output reg busy,
    output reg [10:0] strobes,
    output reg [7:0] p1b_out,
    output reg [5:0] p1c_out,
    output reg [7:0] p2c_out,
    output reg [3:0] adc_chan,
    output reg second_port_b_bit7
);
// =====================================
// Access decode
// Processor pulses cpu_clk_en at 3 MHz; one shift edge per four of them.
wire wr_cyc = io_sel & ~wr_n;
wire rd_cyc = io_sel & ~rd_n;
reg wr_d_r;
reg rd_d_r;
wire wr_go = wr_cyc & ~wr_d_r;
wire rd_go = rd_cyc & ~rd_d_r;
function [10:0] ssio_dec;
    input [3:0] a;
    begin
        ssio_dec = 11'h000;
        if (a < 4'hB) begin
            ssio_dec[a] = 1'b1;
        end
    end
endfunction
// =====================================
// Shifter and strobe
reg [7:0] sh_r;
reg [3:0] cnt_r;
reg [1:0] div_r;
reg [3:0] saddr_r;
always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        wr_d_r <= 1'b0;
        rd_d_r <= 1'b0;
        sh_r <= `SSIO_RST_BYTE;
        cnt_r <= 4'h0;
        div_r <= 2'h0;
        saddr_r <= 4'h0;
        sclk <= 1'b0;
        sdata <= 1'b0;
        busy <= 1'b0;
        strobes <= 11'h000;
    end else begin
        wr_d_r <= wr_cyc;
        rd_d_r <= rd_cyc;
        if (wr_go & strobe_gen_select & ~busy) begin
            saddr_r <= addr;
        end
        if (wr_go & shifter_select & ~busy) begin
            sh_r <= wdata;
            sdata <= wdata[7];
            busy <= 1'b1;
            cnt_r <= 4'h0;
            div_r <= 2'h0;
            strobes <= ssio_dec(strobe_gen_select ? addr : saddr_r);
        end else if (busy & cpu_clk_en) begin
            div_r <= div_r + 2'h1;
            if (div_r == 2'h1) begin
                sclk <= 1'b1;
            end else if (div_r == 2'h3) begin
                sclk <= 1'b0;
                if (cnt_r == `SSIO_NBITS - 4'h1) begin
                    busy <= 1'b0;
                    div_r <= 2'h0;
                    strobes <= 11'h000;
                end else begin
                    cnt_r <= cnt_r + 4'h1;
                    sh_r <= {sh_r[6:0], 1'b0};
                    sdata <= sh_r[6];
                end
            end
        end
    end
end
// =====================================
// ADC and ports
reg [7:0] adc_r;
reg [7:0] adc_cnt_r;
reg adc_run_r;
always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        adc_r <= 8'h00;
        adc_cnt_r <= 8'h00;
        adc_run_r <= 1'b0;
        adc_chan <= 4'h0;
        second_port_b_bit7 <= 1'b0;
        p1b_out <= 8'h00;
        p1c_out <= 6'h00;
        p2c_out <= 8'h00;
        rdata <= 8'h00;
        rdata_valid <= 1'b0;
    end else begin
        rdata_valid <= 1'b0;
        if (wr_go & adc_select) begin
            adc_chan <= addr;
            adc_run_r <= 1'b1;
            adc_cnt_r <= 8'h00;
            second_port_b_bit7 <= 1'b0;
        end else if (adc_run_r) begin
            adc_cnt_r <= adc_cnt_r + 8'h01;
            if (adc_cnt_r == `SSIO_ADC_CYC) begin
                adc_r <= adc_sample;
                adc_run_r <= 1'b0;
                second_port_b_bit7 <= 1'b1;
            end
        end
        // Output latches drive audio, gain speed, mute and BFO lines
        if (wr_go & port_a_device_select) begin
            if (addr[1:0] == `SSIO_PB_ADDR) begin
                p1b_out <= wdata;
            end else if (addr[1:0] == `SSIO_PC_ADDR) begin
                p1c_out <= wdata[5:0];
            end
        end
        if (wr_go & port_b_device_select & (addr[1:0] == `SSIO_PC_ADDR)) begin
            p2c_out <= wdata;
        end
        if (rd_go) begin
            if (adc_select) begin
                rdata <= adc_r;
                rdata_valid <= 1'b1;
            end else if (port_a_device_select & (addr[1:0] == `SSIO_PA_ADDR)) begin
                rdata <= p1_in;
                rdata_valid <= 1'b1;
            end else if (port_b_device_select & (addr[1:0] == `SSIO_PA_ADDR)) begin
                rdata <= p2a_in;
                rdata_valid <= 1'b1;
            end else if (port_b_device_select & (addr[1:0] == `SSIO_PB_ADDR)) begin
                rdata <= {second_port_b_bit7, p2b_in};
                rdata_valid <= 1'b1;
            end
        end
    end
end
endmodule // ssio_top
`default_nettype wire

// File: ssio_top_assertions.sv
`timescale 1ns/100ps
`default_nettype none
// ========
// Shifter, strobe and ADC checks
module ssio_chk (
    input wire clk,
    input wire arst_n,
    input wire io_sel,
    input wire wr_n,
    input wire rd_n,
    input wire [3:0] addr,
    input wire [7:0] wdata,
    input wire shifter_select,
    input wire strobe_gen_select,
    input wire adc_select,
    input wire busy,
    input wire sclk,
    input wire sdata,
    input wire [10:0] strobes,
    input wire rdata_valid,
    input wire second_port_b_bit7
);
    wire w = io_sel & ~wr_n;
    wire r = io_sel & ~rd_n;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_one_strobe: assert property ($onehot0(strobes))
        else $error("two strobes");
    a_strobe_held: assert property (|strobes |-> busy)
        else $error("stray strobe");
    a_clock_idle: assert property (!busy |-> !sclk)
        else $error("idle clock");
    a_start_msb: assert property ($rose(w) && shifter_select && !busy
        |=> busy && sdata == $past(wdata[7])) else $error("bad start");
    a_code_map: assert property ($rose(w) && shifter_select && strobe_gen_select && !busy
        |=> strobes == 11'h001 << $past(addr)) else $error("bad strobe");
    a_frame_len: assert property ($rose(busy) |-> ##85 busy ##[1:15] !busy)
        else $error("bad length");
    a_eoc_time: assert property ($rose(w) && adc_select
        |=> !second_port_b_bit7 ##[60:70] second_port_b_bit7) else $error("bad eoc");
    a_read_done: assert property ($rose(r) && adc_select |-> ##[1:2] rdata_valid)
        else $error("no read");
endmodule // ssio_chk
bind ssio_top ssio_chk ssio_chk_inst (.*);
`default_nettype wire

// File: ssio_dac.sv
`timescale 1ns/100ps
`default_nettype none
// ========
// Serial DAC latch, deaf unless loaded
module ssio_dac (
    input wire sclk,
    input wire sdata,
    input wire load,
    output logic [7:0] word
);
    always @(posedge sclk) if (load) word <= {word[6:0], sdata};
endmodule // ssio_dac
`default_nettype wire

// File: ssio_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
// ========
// Shifter, ADC and port tests
module ssio_top_tb;
    reg clk = 0, arst_n = 0, cpu_clk_en = 0, io_sel = 0, wr_n = 1, rd_n = 1;
    reg [4:0] sel = 5'h00;
    reg [3:0] addr = 4'h0;
    reg [7:0] wdata = 8'h00;
    wire [7:0] rdata, p1b_out, p2c_out, word;
    wire [10:0] strobes;
    wire [3:0] adc_chan;
    wire [5:0] p1c;
    wire sclk, sdata, busy, eoc, rv;
    integer i, j, miscompares = 0, cmp_count = 0, rv_cnt = 0;
    ssio_top ssio_top_inst (.clk(clk), .arst_n(arst_n), .cpu_clk_en(cpu_clk_en), .io_sel(io_sel),
        .wr_n(wr_n), .rd_n(rd_n), .addr(addr), .wdata(wdata), .shifter_select(sel[0]),
        .strobe_gen_select(sel[1]), .adc_select(sel[2]), .port_a_device_select(sel[3]),
        .port_b_device_select(sel[4]), .p1_in(8'h96), .p2a_in(8'h69), .p2b_in(7'h55),
        .adc_sample(8'h3C), .rdata(rdata), .rdata_valid(rv), .sclk(sclk), .sdata(sdata),
        .busy(busy), .strobes(strobes), .p1b_out(p1b_out), .p1c_out(p1c), .p2c_out(p2c_out),
        .adc_chan(adc_chan), .second_port_b_bit7(eoc));
    ssio_dac ssio_dac_inst (.sclk(sclk), .sdata(sdata), .load(strobes[1]), .word(word));
    initial forever #50 clk = ~clk;
    // Read answers are one-cycle pulses, so count them as they pass
    always @(posedge clk) if (rv) rv_cnt <= rv_cnt + 1;
    initial forever begin
        repeat (2) @(negedge clk);
        cpu_clk_en = 1;
        @(negedge clk);
        cpu_clk_en = 0;
    end
    task chk(input [10:0] s, input [10:0] e);
        cmp_count++;
        if (s !== e) begin
            miscompares++;
            $display("[ERR] %0t %h %h", $time, s, e);
        end
    endtask
    task io(input rw, input [4:0] s, input [3:0] a, input [7:0] d);
        io_sel = 1;
        sel = s;
        addr = a;
        wdata = d;
        wr_n = rw;
        rd_n = !rw;
        @(negedge clk);
        {io_sel, sel, wr_n, rd_n} = 8'h03;
        @(negedge clk);
    endtask
    task tally_and_finish;
        $display("compares %0d errors %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #400000;
        miscompares++;
        tally_and_finish;
    end
    initial begin
        repeat (10) @(negedge clk);
        arst_n = 1;
        // Code 11 must light nothing; second write lands while busy
        for (i = 0; i < 12; i++) begin
            io(0, 5'h03, i[3:0], 8'hA5 ^ i[7:0]);
            chk(strobes, 11'h001 << i);
            io(0, 5'h01, 4'h0, 8'h00);
            for (j = 0; j < 200 && busy; j++) @(negedge clk);
            chk(busy, 11'h000);
        end
        chk(word, 11'h0A4);
        // Strobe code kept from its own select; shifter-only address is ignored
        io(0, 5'h02, 4'h1, 8'h00);
        io(0, 5'h01, 4'h6, 8'h3C);
        chk(strobes, 11'h002);
        for (j = 0; j < 200 && busy; j++) @(negedge clk);
        chk(word, 11'h03C);
        io(0, 5'h04, 4'h8, 8'h00);
        chk(adc_chan, 11'h008);
        for (j = 0; j < 100 && !eoc; j++) @(negedge clk);
        io(1, 5'h04, 4'h8, 8'h00);
        chk(rdata, 11'h03C);
        io(1, 5'h10, 4'h1, 8'h00);
        chk(rdata, 11'h0D5);
        io(1, 5'h08, 4'h0, 8'h00);
        chk(rdata, 11'h096);
        io(1, 5'h10, 4'h0, 8'h00);
        chk(rdata, 11'h069);
        chk(rv_cnt, 11'h004);
        io(0, 5'h08, 4'h1, 8'h5A);
        chk(p1b_out, 11'h05A);
        io(0, 5'h08, 4'h2, 8'hFF);
        chk(p1c, 11'h03F);
        io(0, 5'h10, 4'h2, 8'hC3);
        chk(p2c_out, 11'h0C3);
        chk(p1c, 11'h03F);
        tally_and_finish;
    end
endmodule // ssio_top_tb
`default_nettype wire
